// ### src/spk_pkg.sv
// Package for the speakerphone control register bank.
// Assumes a single 16-bit serial word format with the address in the low four bits.
package spk_pkg;
	localparam int WORD_W = 16;
	localparam int REG_COUNT = 6;
	localparam int IDX_W = 3;
	localparam int GAIN_W = 6;
	localparam int FIELD2_W = 2;
	localparam int LEVEL_W = 4;

	// Register codes carried in bits 3..0
	localparam logic [3:0] ADDR_DUPLEX_ECHO = 4'h0;
	localparam logic [3:0] ADDR_TAP_VOLUME = 4'h2;
	localparam logic [3:0] ADDR_DETECTOR_TIMING = 4'h4;
	localparam logic [3:0] ADDR_SUPPRESSION_DEPTH = 4'h6;
	localparam logic [3:0] ADDR_ERLE_GAIN = 4'h8;
	localparam logic [3:0] ADDR_DETECTOR_DISABLE = 4'ha;
	localparam int ADDR_LSB = 0;
	localparam int ADDR_MSB = 3;

	// Register indexes into the storage array
	localparam logic [IDX_W-1:0] IDX_DUPLEX_ECHO = 3'h0;
	localparam logic [IDX_W-1:0] IDX_TAP_VOLUME = 3'h1;
	localparam logic [IDX_W-1:0] IDX_DETECTOR_TIMING = 3'h2;
	localparam logic [IDX_W-1:0] IDX_SUPPRESSION_DEPTH = 3'h3;
	localparam logic [IDX_W-1:0] IDX_ERLE_GAIN = 3'h4;
	localparam logic [IDX_W-1:0] IDX_DETECTOR_DISABLE = 3'h5;

	// Reset words
	localparam logic [WORD_W-1:0] RST_DUPLEX_ECHO = 16'ha400;
	localparam logic [WORD_W-1:0] RST_TAP_VOLUME = 16'h2a02;
	localparam logic [WORD_W-1:0] RST_DETECTOR_TIMING = 16'h0004;
	localparam logic [WORD_W-1:0] RST_SUPPRESSION_DEPTH = 16'h0006;
	localparam logic [WORD_W-1:0] RST_ERLE_GAIN = 16'h0008;
	localparam logic [WORD_W-1:0] RST_DETECTOR_DISABLE = 16'h000a;

	// Register 0 fields
	localparam int R0_PREAMP_EN = 15;
	localparam int R0_HALF_DUPLEX_INHIBIT = 14;
	localparam int R0_DECAY_GRADING_LSB = 12;
	localparam int R0_RX_LEVEL_LSB = 8;
	localparam int R0_TX_SQUELCH_OFF = 7;
	localparam int R0_ACOUSTIC_COEF_LSB = 5;
	localparam int R0_TX_SQUELCH_POLICY = 4;
	// Register 1 fields
	localparam int R1_TX_MARGIN_LSB = 14;
	localparam int R1_TAP_SPLIT_LSB = 12;
	localparam int R1_TX_LEVEL_LSB = 8;
	localparam int R1_RX_SQUELCH_OFF = 7;
	localparam int R1_LINE_COEF_LSB = 5;
	localparam int R1_LINE_AUTO_OFF = 4;
	// Register 2 and 4 fields
	localparam int R2_RX_MARGIN_LSB = 14;
	localparam int R2_NOISE_CLIMB_LSB = 10;
	localparam int R4_LINE_NOISE_GATE_LSB = 8;

	// Level code encoding
	localparam logic [LEVEL_W-1:0] LEVEL_MUTE = 4'hf;
	localparam logic [LEVEL_W-1:0] LEVEL_UNITY = 4'ha;
	localparam logic [GAIN_W-1:0] LEVEL_TOP_DB = 6'h1e;
	localparam logic [GAIN_W-1:0] LEVEL_STEP_DB = 6'h03;

	// Coefficient control and reserved two-bit code
	localparam logic [1:0] COEF_ADAPT = 2'h0;
	localparam logic [1:0] COEF_CLEAR = 2'h1;
	localparam logic [1:0] COEF_FREEZE = 2'h2;
	localparam logic [1:0] CODE_RESERVED = 2'h3;
	localparam logic [1:0] NOISE_GATE_ZERO = 2'h0;

	// Trailing strobe pulses after the gate rises
	localparam logic [2:0] COMMIT_PULSES = 3'h4;

	typedef enum logic [1:0] {
		SPK_COEF_ADAPT,
		SPK_COEF_CLEAR,
		SPK_COEF_FREEZE
	} spk_coef_mode_t;
endpackage

// ### src/spk_ctrl_regs.sv
// Write-only control register bank of the speakerphone processor, loaded serially.
// Assumes strobe_clk, serial_data and frame_gate_n come from a host microcontroller
// and that echo and speech detectors on clk supply the status inputs.
//
// Contract
// - Register 0 bit 15 enables preamp, resets 1
// - Half-duplex fallback unless inhibit bit set
// - Decay grading tapers acoustic canceller only
// - Receive level: +30 dB, -3 dB steps, mute
// - Gain control only above +0 dB level
// - Policy 1: squelch on far speech, no near
// - Policy 0: squelch whenever near speech absent
// - Register 0 bit 7 disables transmit squelch
// - Clear code zeroes coefficients, forces half-duplex
// - Freeze code holds coefficients; 11 reserved
// - Transmit talk margin code 6/9/12 dB
// - Tap split code divides canceller taps
// - Transmit level code, same encoding, reset +0
// - Receive squelch 24 dB unless channel active
// - Line coefficient control adapt/clear/freeze
// - Line canceller re-engage, half-duplex, retrain
// - Receive talk margin code in register 2
// - Noise floor climb rate code in register 2
// - Low four bits address register, bit 0 zero
module spk_ctrl_regs
	import spk_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic strobe_clk,
	input wire logic serial_data,
	input wire logic frame_gate_n,
	input wire logic cancel_insufficient,
	input wire logic rx_speech,
	input wire logic near_speech,
	input wire logic rx_channel_active,
	input wire logic line_path_absent,
	input wire logic line_path_seen,
	input wire logic retrain_done,
	output logic preamp_en_r,
	output logic half_duplex_r,
	output logic [spk_pkg::FIELD2_W-1:0] decay_grading_r,
	output logic signed [spk_pkg::GAIN_W-1:0] rx_gain_db_r,
	output logic rx_mute_r,
	output logic rx_agc_en_r,
	output logic signed [spk_pkg::GAIN_W-1:0] tx_gain_db_r,
	output logic tx_mute_r,
	output logic tx_agc_en_r,
	output logic tx_squelch_r,
	output logic rx_squelch_r,
	output spk_pkg::spk_coef_mode_t acoustic_coef_mode_r,
	output spk_pkg::spk_coef_mode_t line_coef_mode_r,
	output logic [spk_pkg::FIELD2_W-1:0] tx_talk_detect_margin_r,
	output logic [spk_pkg::FIELD2_W-1:0] tap_split_r,
	output logic [spk_pkg::FIELD2_W-1:0] rx_talk_detect_margin_r,
	output logic [spk_pkg::FIELD2_W-1:0] noise_floor_climb_r,
	output logic line_canceller_en_r,
	output logic line_retrain_r,
	output logic [spk_pkg::WORD_W-1:0] detector_timing_word_r,
	output logic [spk_pkg::WORD_W-1:0] suppression_depth_word_r,
	output logic [spk_pkg::WORD_W-1:0] erle_gain_word_r,
	output logic [spk_pkg::WORD_W-1:0] detector_disable_word_r
);
	import spk_pkg::*;

	// Link domain, clocked by the host strobe
	logic [WORD_W-1:0] control_shift_word_r;
	logic [WORD_W-1:0] held_word_r;
	logic [2:0] trail_cnt_r;
	logic commit_tgl_r;
	wire trail_last = (trail_cnt_r == COMMIT_PULSES - 3'h1);

	// Trail counter starts saturated so reset never fakes a commit
	always_ff @(posedge strobe_clk or negedge reset_n) begin
		if (!reset_n) begin
			control_shift_word_r <= '0;
			trail_cnt_r <= COMMIT_PULSES;
		end else if (!frame_gate_n) begin
			control_shift_word_r <= {control_shift_word_r[WORD_W-2:0], serial_data};
			trail_cnt_r <= 3'h0;
		end else if (trail_cnt_r != COMMIT_PULSES) begin
			trail_cnt_r <= trail_cnt_r + 3'h1;
		end
	end

	// Held word stays still until the next frame commits, so clk can sample it later
	always_ff @(posedge strobe_clk or negedge reset_n) begin
		if (!reset_n) begin
			held_word_r <= '0;
			commit_tgl_r <= 1'b0;
		end else if (frame_gate_n && trail_last) begin
			held_word_r <= control_shift_word_r;
			commit_tgl_r <= ~commit_tgl_r;
		end
	end

	// Toggle crossing into clk; word is quasi-static by then
	logic tgl_meta_r;
	logic tgl_sync_r;
	logic tgl_seen_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tgl_meta_r <= 1'b0;
			tgl_sync_r <= 1'b0;
			tgl_seen_r <= 1'b0;
		end else begin
			tgl_meta_r <= commit_tgl_r;
			tgl_sync_r <= tgl_meta_r;
			tgl_seen_r <= tgl_sync_r;
		end
	end

	wire commit_evt = tgl_sync_r ^ tgl_seen_r;
	wire [3:0] wr_addr = held_word_r[ADDR_MSB:ADDR_LSB];
	wire addr_ok = !wr_addr[0] && (wr_addr <= ADDR_DETECTOR_DISABLE);
	wire [IDX_W-1:0] wr_idx = wr_addr[IDX_W:1];

	// Register storage, one flip-flop word per register
	logic [WORD_W-1:0] regs_r [REG_COUNT];
	localparam logic [WORD_W-1:0] RST_WORDS [REG_COUNT] = '{RST_DUPLEX_ECHO,
		RST_TAP_VOLUME, RST_DETECTOR_TIMING, RST_SUPPRESSION_DEPTH,
		RST_ERLE_GAIN, RST_DETECTOR_DISABLE};

	generate
		for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					regs_r[i] <= RST_WORDS[i];
				end else if (commit_evt && addr_ok && wr_idx == IDX_W'(i)) begin
					regs_r[i] <= held_word_r;
				end
			end
		end
	endgenerate

	wire [WORD_W-1:0] reg0 = regs_r[IDX_DUPLEX_ECHO];
	wire [WORD_W-1:0] reg1 = regs_r[IDX_TAP_VOLUME];
	wire [WORD_W-1:0] reg2 = regs_r[IDX_DETECTOR_TIMING];
	wire [WORD_W-1:0] reg4 = regs_r[IDX_ERLE_GAIN];

	// Field decode
	wire hd_inhibit = reg0[R0_HALF_DUPLEX_INHIBIT];
	wire [LEVEL_W-1:0] rx_code = reg0[R0_RX_LEVEL_LSB +: LEVEL_W];
	wire [LEVEL_W-1:0] tx_code = reg1[R1_TX_LEVEL_LSB +: LEVEL_W];
	wire [1:0] acc_code = reg0[R0_ACOUSTIC_COEF_LSB +: 2];
	wire [1:0] line_code = reg1[R1_LINE_COEF_LSB +: 2];
	wire [1:0] noise_gate = reg4[R4_LINE_NOISE_GATE_LSB +: 2];
	wire auto_off = reg1[R1_LINE_AUTO_OFF];
	wire preamp_bit = reg0[R0_PREAMP_EN];
	wire [FIELD2_W-1:0] decay_code = reg0[R0_DECAY_GRADING_LSB +: FIELD2_W];
	wire tx_squelch_off = reg0[R0_TX_SQUELCH_OFF];
	wire tx_squelch_policy = reg0[R0_TX_SQUELCH_POLICY];
	wire rx_squelch_off = reg1[R1_RX_SQUELCH_OFF];
	wire [FIELD2_W-1:0] tx_margin_code = reg1[R1_TX_MARGIN_LSB +: FIELD2_W];
	wire [FIELD2_W-1:0] tap_code = reg1[R1_TAP_SPLIT_LSB +: FIELD2_W];
	wire [FIELD2_W-1:0] rx_margin_code = reg2[R2_RX_MARGIN_LSB +: FIELD2_W];
	wire [FIELD2_W-1:0] climb_code = reg2[R2_NOISE_CLIMB_LSB +: FIELD2_W];
	wire rx_mute_nxt = (rx_code == LEVEL_MUTE);
	wire tx_mute_nxt = (tx_code == LEVEL_MUTE);
	wire rx_agc_nxt = (rx_code < LEVEL_UNITY);
	wire tx_agc_nxt = (tx_code < LEVEL_UNITY);

	// Gain in dB: top level minus three per code step
	wire [GAIN_W-1:0] rx_step_db = GAIN_W'(LEVEL_STEP_DB * rx_code);
	wire [GAIN_W-1:0] tx_step_db = GAIN_W'(LEVEL_STEP_DB * tx_code);
	wire [GAIN_W-1:0] rx_gain_nxt = LEVEL_TOP_DB - rx_step_db;
	wire [GAIN_W-1:0] tx_gain_nxt = LEVEL_TOP_DB - tx_step_db;

	// Squelch decisions
	wire tx_squelch_cond = tx_squelch_policy ?
		(rx_speech && !near_speech) :
		!near_speech;
	wire tx_squelch_nxt = !tx_squelch_off && tx_squelch_cond;
	wire rx_squelch_nxt = !rx_squelch_off && !rx_channel_active;

	// Reserved coefficient codes keep the previous mode
	function automatic spk_coef_mode_t coef_decode(input logic [1:0] code,
			input spk_coef_mode_t prev);
		spk_coef_mode_t m;
		m = prev;
		unique case (code)
			COEF_ADAPT: m = SPK_COEF_ADAPT;
			COEF_CLEAR: m = SPK_COEF_CLEAR;
			COEF_FREEZE: m = SPK_COEF_FREEZE;
			CODE_RESERVED: m = prev;
		endcase
		return m;
	endfunction

	wire spk_coef_mode_t acc_nxt = coef_decode(acc_code, acoustic_coef_mode_r);
	wire spk_coef_mode_t line_nxt = coef_decode(line_code, line_coef_mode_r);

	// Line canceller switch-off and automatic re-engage
	wire line_drop = line_canceller_en_r && line_path_absent && (noise_gate != NOISE_GATE_ZERO);
	wire line_reengage = !line_canceller_en_r && line_path_seen && !auto_off;
	wire line_en_nxt = line_reengage ? 1'b1 : (line_drop ? 1'b0 : line_canceller_en_r);
	// Re-engage wins over a same-cycle train done so retraining is never skipped
	wire retrain_nxt = line_reengage || (line_retrain_r && !retrain_done);

	wire hd_cause = cancel_insufficient || (acc_nxt == SPK_COEF_CLEAR) || retrain_nxt;
	wire half_duplex_nxt = !hd_inhibit && hd_cause;

	// Line canceller state and its retrain window
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			line_canceller_en_r <= 1'b1;
			line_retrain_r <= 1'b0;
		end else begin
			line_canceller_en_r <= line_en_nxt;
			line_retrain_r <= retrain_nxt;
		end
	end

	// Power-up starts in half-duplex while the filters train
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			half_duplex_r <= 1'b1;
		end else begin
			half_duplex_r <= half_duplex_nxt;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acoustic_coef_mode_r <= SPK_COEF_ADAPT;
			line_coef_mode_r <= SPK_COEF_ADAPT;
		end else begin
			acoustic_coef_mode_r <= acc_nxt;
			line_coef_mode_r <= line_nxt;
		end
	end

	// Receive level outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_gain_db_r <= '0;
			rx_mute_r <= 1'b0;
			rx_agc_en_r <= 1'b0;
		end else begin
			rx_gain_db_r <= rx_gain_nxt;
			rx_mute_r <= rx_mute_nxt;
			rx_agc_en_r <= rx_agc_nxt;
		end
	end

	// Transmit level outputs, same encoding as receive
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_gain_db_r <= '0;
			tx_mute_r <= 1'b0;
			tx_agc_en_r <= 1'b0;
		end else begin
			tx_gain_db_r <= tx_gain_nxt;
			tx_mute_r <= tx_mute_nxt;
			tx_agc_en_r <= tx_agc_nxt;
		end
	end

	// Plain field outputs and the two squelch decisions, one register each
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			preamp_en_r <= 1'b1;
		end else begin
			preamp_en_r <= preamp_bit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			decay_grading_r <= '0;
		end else begin
			decay_grading_r <= decay_code;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_squelch_r <= 1'b0;
		end else begin
			tx_squelch_r <= tx_squelch_nxt;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_squelch_r <= 1'b0;
		end else begin
			rx_squelch_r <= rx_squelch_nxt;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_talk_detect_margin_r <= '0;
			tap_split_r <= '0;
		end else begin
			tx_talk_detect_margin_r <= tx_margin_code;
			tap_split_r <= tap_code;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_talk_detect_margin_r <= '0;
			noise_floor_climb_r <= '0;
		end else begin
			rx_talk_detect_margin_r <= rx_margin_code;
			noise_floor_climb_r <= climb_code;
		end
	end

	// Raw words kept whole; apart from the reg2 margin/climb and reg4 noise gate fields, they are decoded outside this block
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			detector_timing_word_r <= '0;
		end else begin
			detector_timing_word_r <= reg2;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			suppression_depth_word_r <= '0;
		end else begin
			suppression_depth_word_r <= regs_r[IDX_SUPPRESSION_DEPTH];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			erle_gain_word_r <= '0;
		end else begin
			erle_gain_word_r <= reg4;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			detector_disable_word_r <= '0;
		end else begin
			detector_disable_word_r <= regs_r[IDX_DETECTOR_DISABLE];
		end
	end
endmodule

// ### dv/spk_host.sv
// Host microcontroller model driving the serial control port.
// Assumes the bench calls send once the previous send has returned.
module spk_host (
	output logic strobe_clk,
	output logic serial_data,
	output logic frame_gate_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		strobe_clk = 1'b0;
		serial_data = 1'b0;
		frame_gate_n = 1'b1;
	end
	// Strobe runs only inside a transfer, 160 ns period
	task automatic pulse(input int n);
		repeat (n) begin
			#80 strobe_clk = 1'b1;
			#80 strobe_clk = 1'b0;
		end
	endtask
	task automatic send(input logic [15:0] w, input int trail);
		frame_gate_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_data = w[i];
			pulse(1);
		end
		frame_gate_n = 1'b1;
		// Released line shows the inverse so a stale bit cannot pass
		serial_data = ~serial_data;
		pulse(trail);
		#125000;
	endtask
endmodule

// ### dv/spk_ctrl_regs_chk.sv
// Concurrent checks on the control register bank outputs.
// Assumes binding to spk_ctrl_regs; all checks run on clk.
module spk_ctrl_regs_chk
	import spk_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic near_speech,
	input wire logic rx_channel_active,
	input wire logic line_path_absent,
	input wire logic line_path_seen,
	input wire logic retrain_done,
	input wire logic rx_mute_r,
	input wire logic rx_agc_en_r,
	input wire logic signed [spk_pkg::GAIN_W-1:0] rx_gain_db_r,
	input wire logic tx_squelch_r,
	input wire logic rx_squelch_r,
	input wire spk_pkg::spk_coef_mode_t acoustic_coef_mode_r,
	input wire logic line_canceller_en_r,
	input wire logic line_retrain_r,
	input wire logic [spk_pkg::WORD_W-1:0] erle_gain_word_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_retrain_end;
		line_retrain_r && retrain_done && !line_path_seen;
	endsequence
	property p_rx_agc; rx_agc_en_r == (!rx_mute_r && rx_gain_db_r > 0); endproperty
	a_rx_agc: assert property (p_rx_agc) else $error("rx gain control wrong");
	property p_tx_near; $past(near_speech) |-> !tx_squelch_r; endproperty
	a_tx_near: assert property (p_tx_near) else $error("tx squelch during speech");
	property p_rx_rel; $past(rx_channel_active) |-> !rx_squelch_r; endproperty
	a_rx_rel: assert property (p_rx_rel) else $error("rx squelch not released");
	property p_coef; acoustic_coef_mode_r != 2'h3; endproperty
	a_coef: assert property (p_coef) else $error("coefficient mode invalid");
	property p_re_on; $rose(line_retrain_r) |-> line_canceller_en_r && $past(line_path_seen); endproperty
	a_re_on: assert property (p_re_on) else $error("retrain without re-engage");
	property p_re_off; s_retrain_end |=> !line_retrain_r; endproperty
	a_re_off: assert property (p_re_off) else $error("retrain did not end");
	property p_drop; $fell(line_canceller_en_r) |-> $past(line_path_absent); endproperty
	a_drop: assert property (p_drop) else $error("line canceller dropped");
	property p_addr; $changed(erle_gain_word_r) |-> erle_gain_word_r[3:0] == 4'h8; endproperty
	a_addr: assert property (p_addr) else $error("word landed in wrong register");
endmodule
bind spk_ctrl_regs spk_ctrl_regs_chk i_chk(.clk, .reset_n, .near_speech, .rx_channel_active,
	.line_path_absent, .line_path_seen, .retrain_done, .rx_mute_r, .rx_agc_en_r, .rx_gain_db_r,
	.tx_squelch_r, .rx_squelch_r, .acoustic_coef_mode_r, .line_canceller_en_r, .line_retrain_r,
	.erle_gain_word_r);

// ### dv/spk_ctrl_regs_bench.sv
// Self-checking bench for the serial control register bank.
// Assumes the host model and the bound checker beside the design.
module spk_ctrl_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import spk_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	// Status inputs: insufficient, rx speech, near, active, absent, seen, done
	logic [6:0] st = 7'h00;
	logic strobe_clk, serial_data, frame_gate_n, preamp_en_r, half_duplex_r, rx_mute_r;
	logic rx_agc_en_r, tx_mute_r, tx_agc_en_r, tx_squelch_r, rx_squelch_r;
	logic line_canceller_en_r, line_retrain_r;
	logic [1:0] decay_grading_r, tx_talk_detect_margin_r, tap_split_r;
	logic [1:0] rx_talk_detect_margin_r, noise_floor_climb_r;
	logic signed [GAIN_W-1:0] rx_gain_db_r, tx_gain_db_r;
	spk_coef_mode_t acoustic_coef_mode_r, line_coef_mode_r;
	logic [WORD_W-1:0] detector_timing_word_r, suppression_depth_word_r;
	logic [WORD_W-1:0] erle_gain_word_r, detector_disable_word_r;
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	spk_host i_host(.strobe_clk, .serial_data, .frame_gate_n);
	spk_ctrl_regs i_dut(.clk, .reset_n, .strobe_clk, .serial_data, .frame_gate_n,
		.cancel_insufficient(st[6]), .rx_speech(st[5]), .near_speech(st[4]),
		.rx_channel_active(st[3]), .line_path_absent(st[2]), .line_path_seen(st[1]),
		.retrain_done(st[0]), .preamp_en_r, .half_duplex_r, .decay_grading_r, .rx_gain_db_r,
		.rx_mute_r, .rx_agc_en_r, .tx_gain_db_r, .tx_mute_r, .tx_agc_en_r, .tx_squelch_r,
		.rx_squelch_r, .acoustic_coef_mode_r, .line_coef_mode_r, .tx_talk_detect_margin_r,
		.tap_split_r, .rx_talk_detect_margin_r, .noise_floor_climb_r, .line_canceller_en_r,
		.line_retrain_r, .detector_timing_word_r, .suppression_depth_word_r, .erle_gain_word_r,
		.detector_disable_word_r);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Status outputs are registered, so three edges is ample
	task automatic drive(input logic [6:0] v);
		@(posedge clk);
		#1 st = v;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic t_reset;
		chk(preamp_en_r, 1);
		chk(decay_grading_r, 2);
		chk({rx_gain_db_r, rx_agc_en_r}, {6'd18, 1'b1});
		chk({tx_gain_db_r, tx_agc_en_r}, 0);
		chk(tap_split_r, 2);
		chk({tx_talk_detect_margin_r, rx_talk_detect_margin_r, noise_floor_climb_r}, 0);
		chk(line_coef_mode_r, SPK_COEF_ADAPT);
		chk(detector_disable_word_r, 16'h000a);
		drive(7'h40);
		chk(half_duplex_r, 1);
	endtask
	task automatic t_reg0;
		i_host.send(16'h5ad0, 4);
		chk({preamp_en_r, decay_grading_r}, 3'h1);
		chk({rx_gain_db_r, rx_agc_en_r}, 0);
		chk(acoustic_coef_mode_r, SPK_COEF_FREEZE);
		chk(half_duplex_r, 0);
		// Far speech only, so squelch would engage but for the off bit
		drive(7'h20);
		chk(tx_squelch_r, 0);
		i_host.send(16'hbf30, 4);
		chk({rx_mute_r, decay_grading_r}, 3'h7);
		chk({acoustic_coef_mode_r, half_duplex_r}, {SPK_COEF_CLEAR, 1'b1});
		chk(tx_squelch_r, 1);
		drive(7'h00);
		chk(tx_squelch_r, 0);
		// Host sends legal field codes only
		i_host.send(16'hbf50, 4);
		chk({acoustic_coef_mode_r, half_duplex_r}, {SPK_COEF_FREEZE, 1'b0});
		i_host.send(16'ha400, 4);
		drive(7'h00);
		chk(tx_squelch_r, 1);
		drive(7'h10);
		chk(tx_squelch_r, 0);
	endtask
	task automatic t_reg1;
		i_host.send(16'hb122, 4);
		chk({tx_talk_detect_margin_r, tap_split_r}, 4'hb);
		chk({tx_gain_db_r, tx_agc_en_r, tx_mute_r}, {6'd27, 2'h2});
		chk(line_coef_mode_r, SPK_COEF_CLEAR);
		chk(rx_squelch_r, 1);
		drive(7'h08);
		chk(rx_squelch_r, 0);
	endtask
	task automatic t_regs;
		i_host.send(16'h8804, 4);
		chk({rx_talk_detect_margin_r, noise_floor_climb_r}, 4'ha);
		i_host.send(16'h1237, 4);
		i_host.send(16'h123c, 4);
		i_host.send(16'h1236, 3);
		chk(suppression_depth_word_r, 16'h0006);
		i_host.send(16'h1236, 4);
		chk(suppression_depth_word_r, 16'h1236);
		chk(detector_timing_word_r, 16'h8804);
	endtask
	task automatic t_line;
		i_host.send(16'h0108, 4);
		drive(7'h04);
		chk(line_canceller_en_r, 0);
		drive(7'h02);
		chk({line_canceller_en_r, line_retrain_r, half_duplex_r}, 3'h7);
		drive(7'h01);
		chk(line_retrain_r, 0);
		i_host.send(16'hb132, 4);
		drive(7'h04);
		drive(7'h02);
		chk({line_canceller_en_r, line_retrain_r}, 2'h0);
	endtask
	// Mid-run reset must restore the ERLE word, tap split and line canceller defaults
	task automatic t_rearm;
		@(posedge clk);
		#1 reset_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(erle_gain_word_r, 16'h0008);
		chk({tap_split_r, line_canceller_en_r, line_retrain_r}, 4'ha);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		t_reset;
		t_reg0;
		t_reg1;
		t_regs;
		t_line;
		t_rearm;
		tally_and_finish;
	end
endmodule
